// [rtl/msp_device.sv]
// Device end of the metering serial port with read ones tally.
// Summary of operation
// - Clear tally before first read bit.
// - Add each sent bit to tally.
// - Tally read tallies its own bits.
// - Reset then chip select enters command mode.
// - Command: top bit direction, six address bits.
// - Last register bit returns to command mode.
// - Capture input on falling serial clock.
// - Launch output on rising serial clock.
// - Chip select fall resets serial port.
// - Chip select rise aborts, releases output.
// - Tied-low select: host finishes transfers.
// - Top bit one means write.
// - Host spaces write bytes 4 us.
// - Partial write byte is discarded.
// - Up to three bytes, MSB first, right-justified.
// - Analog halt bit zeroes waveform samples.
// - Static master clock halts processing.
// - Top bit zero means read.
// - Output released on last falling edge.
// - Whole register captured at read start.
// - Host waits 4 us before read.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "msp_params.svh"
module msp_device (
  input  wire logic              CLK_I,
  input  wire logic              RST_B_I,
  msp_link_if.device             LINK,
  input  wire msp_pkg::msp_word_t SAMPLE_I,
  output logic [15:0]            MODE_O,
  output logic [7:0]             SCRATCH_O,
  output msp_pkg::msp_word_t     WAVE_O
);
  import msp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] cs_s_q, ck_s_q, di_s_q;
  logic       cs_d1_q, ck_d1_q;
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cs_s_q  <= 2'b11;
      // The serial clock idles high, so the detector starts high to avoid a false edge after reset.
      ck_s_q  <= 2'b11;
      di_s_q  <= 2'b00;
      cs_d1_q <= 1'b1;
      ck_d1_q <= 1'b1;
    end else begin
      cs_s_q  <= {cs_s_q[0], LINK.chip_sel_n};
      ck_s_q  <= {ck_s_q[0], LINK.sclk};
      di_s_q  <= {di_s_q[0], LINK.din};
      cs_d1_q <= cs_s_q[1];
      ck_d1_q <= ck_s_q[1];
    end
  end
  wire cs_n     = cs_s_q[1];
  wire cs_fall  = cs_d1_q & ~cs_n;
  wire cs_rise  = ~cs_d1_q & cs_n;
  wire sck_rise = ~ck_d1_q & ck_s_q[1] & ~cs_n;
  wire sck_fall = ck_d1_q & ~ck_s_q[1] & ~cs_n;
  wire din_bit  = di_s_q[1];

  // ----------------------------------------------------------------
  // Register widths and read decode
  // ----------------------------------------------------------------
  msp_state_t state_q;
  logic [5:0] addr_q;
  logic [7:0] shin_q;
  logic [2:0] bit_q;
  logic [1:0] byte_q;
  logic [23:0] shout_q;
  logic [4:0] rcnt_q;
  logic [5:0] tally_q;
  logic [15:0] mode_q;
  logic [7:0]  scratch_q;
  logic        dout_q, oe_q;

  wire [7:0]  in_byte  = {shin_q[6:0], din_bit};
  wire        cmd_wr   = in_byte[`MSP_CMD_WRITE_BIT];
  wire [5:0]  cmd_addr = in_byte[5:0];
  wire [1:0]  nbytes   = (addr_q == `MSP_ADDR_WAVE) ? 2'd3 :
                         (addr_q == `MSP_ADDR_MODE) ? 2'd2 : 2'd1;
  // The whole register is captured when the command ends, so later updates cannot tear a read.
  wire [23:0] rd_val   = (cmd_addr == `MSP_ADDR_WAVE)    ? WAVE_O :
                         (cmd_addr == `MSP_ADDR_MODE)    ? {mode_q, 8'h00} :
                         (cmd_addr == `MSP_ADDR_SCRATCH) ? {scratch_q, 16'h0000} :
                         (cmd_addr == `MSP_ADDR_TALLY)   ? {2'b00, tally_q, 16'h0000} :
                         24'h000000;

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q   <= MSP_ST_CMD;
      addr_q    <= 6'h00;
      shin_q    <= 8'h00;
      bit_q     <= 3'd0;
      byte_q    <= 2'd0;
      shout_q   <= 24'h000000;
      rcnt_q    <= 5'd0;
      tally_q   <= 6'h00;
      mode_q    <= `MSP_MODE_RESET;
      scratch_q <= 8'h00;
      dout_q    <= 1'b0;
      oe_q      <= 1'b0;
    end else if (cs_fall || cs_rise) begin
      state_q <= MSP_ST_CMD;
      bit_q   <= 3'd0;
      byte_q  <= 2'd0;
      oe_q    <= 1'b0;
    end else begin
      unique case (state_q)
        MSP_ST_CMD: if (sck_fall) begin
          shin_q <= in_byte;
          bit_q  <= bit_q + 3'd1;
          if (bit_q == 3'd7) begin
            addr_q <= cmd_addr;
            byte_q <= 2'd0;
            if (cmd_wr) begin
              state_q <= MSP_ST_WRITE;
            end else begin
              state_q <= MSP_ST_READ;
              shout_q <= rd_val;
              rcnt_q  <= 5'd0;
            end
          end
        end
        MSP_ST_WRITE: if (sck_fall) begin
          shin_q <= in_byte;
          bit_q  <= bit_q + 3'd1;
          if (bit_q == 3'd7) begin
            byte_q <= byte_q + 2'd1;
            if (addr_q == `MSP_ADDR_MODE && byte_q == 2'd0) mode_q[15:8] <= in_byte;
            if (addr_q == `MSP_ADDR_MODE && byte_q == 2'd1) mode_q[7:0]  <= in_byte;
            if (addr_q == `MSP_ADDR_SCRATCH) scratch_q <= in_byte;
            if (byte_q + 2'd1 == nbytes) state_q <= MSP_ST_CMD;
          end
        end
        MSP_ST_READ: begin
          if (sck_rise) begin
            dout_q  <= shout_q[23];
            shout_q <= {shout_q[22:0], 1'b0};
            oe_q    <= 1'b1;
            tally_q <= (rcnt_q == 5'd0) ? {5'd0, shout_q[23]}
                                        : tally_q + {5'd0, shout_q[23]};
            rcnt_q  <= rcnt_q + 5'd1;
          end
          if (sck_fall && rcnt_q == {nbytes, 3'b000}) begin
            oe_q    <= 1'b0;
            state_q <= MSP_ST_CMD;
          end
        end
        default: state_q <= MSP_ST_CMD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Analog front end and outputs
  // ----------------------------------------------------------------
  // All processing runs on CLK_I alone: a static clock freezes it, and samples resume
  // once the clock returns, while the halt bit is clear.
  logic [23:0] wave_q;
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) wave_q <= 24'h000000;
    else wave_q <= mode_q[`MSP_MODE_HALT_BIT] ? 24'h000000 : SAMPLE_I;
  end
  assign WAVE_O       = wave_q;
  assign MODE_O       = mode_q;
  assign SCRATCH_O    = scratch_q;
  assign LINK.dout    = dout_q;
  assign LINK.dout_oe = oe_q & ~cs_n;
endmodule

// [rtl/msp_host.sv]
// Host controller for the metering serial port, AXI4-Lite command registers.
`timescale 1ns/1ns
`include "msp_params.svh"
module msp_host #(
  parameter int BYTE_GAP = `MSP_BYTE_GAP_CYC
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  msp_link_if.host         LINK,
  input  wire logic [3:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [3:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I
);
  import msp_pkg::*;

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic        aw_q, w_q, bv_q, rv_q, busy_q, go_q;
  logic [3:0]  awa_q;
  logic [31:0] wd_q, rd_q, ctrl_q, wdat_q, rdat_q;
  wire aw_take = AWVALID_I & ~aw_q & ~bv_q;
  wire w_take  = WVALID_I & ~w_q & ~bv_q;
  wire ar_take = ARVALID_I & ~rv_q;
  wire [31:0] rd_mux = (ARADDR_I == `MSP_REG_CTRL)  ? ctrl_q :
                       (ARADDR_I == `MSP_REG_WDATA) ? wdat_q :
                       (ARADDR_I == `MSP_REG_RDATA) ? rdat_q :
                       (ARADDR_I == `MSP_REG_STAT)  ? {31'h0, busy_q} : 32'h0;
  wire do_write = aw_q & w_q & ~bv_q;
  assign AWREADY_O = ~aw_q & ~bv_q;
  assign WREADY_O  = ~w_q & ~bv_q;
  assign ARREADY_O = ~rv_q;
  assign BVALID_O  = bv_q;
  assign BRESP_O   = 2'b00;
  assign RVALID_O  = rv_q;
  assign RRESP_O   = 2'b00;
  assign RDATA_O   = rd_q;

  // ----------------------------------------------------------------
  // Serial sequencer: command byte then 1..3 data bytes
  // ----------------------------------------------------------------
  logic [3:0]  div_q;
  logic        sck_q, cs_q, do_q;
  logic [31:0] sh_q;
  logic [5:0]  left_q;
  logic [2:0]  bcnt_q;
  logic [15:0] gap_q;
  logic [1:0]  ds_q;
  wire  [1:0]  nb        = (ctrl_q[9:8] == 2'd0) ? 2'd1 : ctrl_q[9:8];
  wire         tick      = (div_q == 4'(`MSP_SCLK_HALF_CYC - 1));
  // Command byte: bit 7 selects write, low six bits address; data right-justified.
  wire  [31:0] frame     = {ctrl_q[7], 1'b0, ctrl_q[5:0], wdat_q[23:0] << (5'd24 - {nb, 3'b000})};
  // A released data-out line is read as its pull-up level, never as a stale bit.
  wire         dout_line = LINK.dout_oe ? LINK.dout : 1'b1;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
      awa_q <= 4'h0; wd_q <= 32'h0; rd_q <= 32'h0;
      ctrl_q <= 32'h0; wdat_q <= 32'h0; go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (aw_take) begin aw_q <= 1'b1; awa_q <= AWADDR_I; end
      if (w_take) begin w_q <= 1'b1; wd_q <= WDATA_I; end
      if (do_write) begin
        aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b1;
        if (awa_q == `MSP_REG_CTRL && !busy_q) begin ctrl_q <= wd_q; go_q <= 1'b1; end
        if (awa_q == `MSP_REG_WDATA) wdat_q <= wd_q;
      end
      if (bv_q && BREADY_I) bv_q <= 1'b0;
      if (ar_take) begin rv_q <= 1'b1; rd_q <= rd_mux; end
      if (rv_q && RREADY_I) rv_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      busy_q <= 1'b0;
      div_q  <= 4'h0;
      sck_q  <= 1'b1;
      cs_q   <= 1'b1;
      do_q   <= 1'b0;
      sh_q   <= 32'h0;
      left_q <= 6'd0;
      bcnt_q <= 3'd0;
      gap_q  <= 16'h0;
      rdat_q <= 32'h0;
      ds_q   <= 2'b11;
    end else begin
      ds_q <= {ds_q[0], dout_line};
      if (gap_q != 16'h0) gap_q <= gap_q - 16'h1;
      if (go_q) begin
        busy_q <= 1'b1;
        cs_q   <= 1'b0;
        div_q  <= 4'h0;
        bcnt_q <= 3'd0;
        left_q <= {1'b0, nb, 3'b000} + 6'd8;
        // The first bit stands on din before the first falling edge, so it meets setup there.
        do_q   <= frame[31];
        sh_q   <= {frame[30:0], 1'b0};
      end else if (busy_q && left_q == 6'd0) begin
        if (tick) begin
          cs_q   <= 1'b1;
          busy_q <= 1'b0;
          sck_q  <= 1'b1;
        end
        div_q <= tick ? 4'h0 : div_q + 4'h1;
      end else if (busy_q && (gap_q == 16'h0 || !sck_q)) begin
        div_q <= tick ? 4'h0 : div_q + 4'h1;
        if (tick) begin
          sck_q <= ~sck_q;
          if (sck_q) begin
            // Falling edge: the device takes din, and the bit it launched on the last rise is read back.
            left_q <= left_q - 6'd1;
            bcnt_q <= bcnt_q + 3'd1;
            rdat_q <= {rdat_q[30:0], ds_q[1]};
            // The end of every byte holds off the next one for the write spacing.
            if (bcnt_q == 3'd7) gap_q <= 16'(BYTE_GAP);
          end else begin
            do_q <= sh_q[31];
            sh_q <= {sh_q[30:0], 1'b0};
          end
        end
      end
    end
  end
  assign LINK.chip_sel_n = cs_q;
  assign LINK.sclk       = sck_q;
  assign LINK.din        = do_q;
endmodule

// [rtl/msp_link_if.sv]
// Serial link between the metering device and its host controller.
`timescale 1ns/1ns
interface msp_link_if;
  logic chip_sel_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  modport device (input chip_sel_n, input sclk, input din, output dout, output dout_oe);
  modport host (output chip_sel_n, output sclk, output din, input dout, input dout_oe);
endinterface

// [rtl/msp_params.svh]
// Constants for the metering serial port and its host controller.
`ifndef MSP_PARAMS_SVH
`define MSP_PARAMS_SVH
`define MSP_CMD_WRITE_BIT   7
`define MSP_ADDR_W          6
`define MSP_TALLY_W         6
`define MSP_ADDR_WAVE       6'h01
`define MSP_ADDR_MODE       6'h09
`define MSP_ADDR_SCRATCH    6'h0a
`define MSP_ADDR_TALLY      6'h3e
`define MSP_MODE_RESET      16'h000c
`define MSP_MODE_HALT_BIT   4
`define MSP_BYTE_GAP_NS     4000
`define MSP_CLK_NS          10
`define MSP_BYTE_GAP_CYC    ((`MSP_BYTE_GAP_NS + `MSP_CLK_NS - 1) / `MSP_CLK_NS)
`define MSP_SCLK_HALF_CYC   8
`define MSP_REG_CTRL        4'h0
`define MSP_REG_WDATA       4'h4
`define MSP_REG_RDATA       4'h8
`define MSP_REG_STAT        4'hc
`endif

// [rtl/msp_pkg.sv]
// Types shared by both ends of the metering serial port.
package msp_pkg;
  typedef enum logic [1:0] {
    MSP_ST_CMD   = 2'b00,
    MSP_ST_WRITE = 2'b01,
    MSP_ST_READ  = 2'b10,
    MSP_ST_DONE  = 2'b11
  } msp_state_t;
  typedef logic [23:0] msp_word_t;
endpackage

// [sim/metering_serial_port_checksum_tb.sv]
// Self-checking bench: host controller and metering device joined over the link.
`timescale 1ns/1ns
`include "msp_params.svh"
module metering_serial_port_checksum_tb;
  import msp_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  msp_word_t   sample = 24'h123456, wave;
  logic [15:0] mode;
  logic [7:0]  scratch;
  int          err_count = 0;
  int          checks = 0;
  msp_link_if link();
  msp_host #(.BYTE_GAP(`MSP_BYTE_GAP_CYC)) msp_host_i (.CLK_I(clk), .RST_B_I(rst_b), .LINK(link),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
    .RVALID_O(rvalid), .RREADY_I(rready));
  msp_device msp_device_i (.CLK_I(clk), .RST_B_I(rst_b), .LINK(link), .SAMPLE_I(sample),
    .MODE_O(mode), .SCRATCH_O(scratch), .WAVE_O(wave));
  msp_link_asserts msp_link_asserts_i (.CLK_I(clk), .RST_B_I(rst_b), .chip_sel_n(link.chip_sel_n),
    .sclk(link.sclk), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe));
  always #5 clk = ~clk;
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b) begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid && bready) b = 1'b1;
    end
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    logic r;
    r = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!r) begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid && rready) begin
        r = 1'b1;
        d = rdata;
      end
    end
    rready <= 1'b0;
  endtask
  // Starts one link transfer and polls the busy flag; the trailing wait keeps a read clear of the last write.
  task automatic xfer(input logic [31:0] ctrl, input logic [31:0] d);
    axi_wr(`MSP_REG_WDATA, d);
    axi_wr(`MSP_REG_CTRL, ctrl);
    rd = 32'h1;
    while (rd[0]) axi_rd(`MSP_REG_STAT, rd);
    repeat (`MSP_BYTE_GAP_CYC) @(posedge clk);
    axi_rd(`MSP_REG_RDATA, rd);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk({16'h0, mode}, {16'h0, `MSP_MODE_RESET});
    xfer(32'h08a, 32'h5a);
    chk({24'h0, scratch}, 32'h5a);
    xfer(32'h00a, 32'h0);
    chk(rd & 32'hff, 32'h5a);
    xfer(32'h03e, 32'h0);
    chk(rd & 32'hff, 32'h04);
    xfer(32'h03e, 32'h0);
    chk(rd & 32'hff, 32'h01);
    xfer(32'h03e, 32'h0);
    chk(rd & 32'hff, 32'h01);
    xfer(32'h301, 32'h0);
    chk(rd & 32'hffffff, 32'h123456);
    xfer(32'h03e, 32'h0);
    chk(rd & 32'hff, 32'h09);
    xfer(32'h289, 32'h001c);
    chk({16'h0, mode}, 32'h1c);
    repeat (8) @(posedge clk);
    chk({8'h0, wave}, 32'h0);
    xfer(32'h209, 32'h0);
    chk(rd & 32'hffff, 32'h1c);
    xfer(32'h289, 32'h000c);
    repeat (8) @(posedge clk);
    chk({8'h0, wave}, 32'h123456);
    results();
  end
  initial begin
    #500000;
    err_count++;
    results();
  end
endmodule

// [sim/msp_link_asserts.sv]
// Concurrent checks on the serial link between the metering device and its host.
`timescale 1ns/1ns
`include "msp_params.svh"
module msp_link_asserts (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic chip_sel_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic       sclk_q;
  logic [5:0] cnt_q;
  logic [7:0] cmd_q;
  logic [5:0] lim;
  logic       fall;
  logic       lim_hit;
  logic       byte_end;
  logic [15:0] gap_cnt_q;
  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  // The tracker follows the bus at the pins, so it needs no knowledge of the device internals.
  assign fall    = sclk_q && !sclk;
  assign lim     = (cmd_q[5:0] == `MSP_ADDR_WAVE) ? 6'h20 : (cmd_q[5:0] == `MSP_ADDR_MODE) ? 6'h18 : 6'h10;
  assign lim_hit = (cnt_q >= lim);
  assign byte_end = fall && !chip_sel_n && (cnt_q[2:0] == 3'd7);
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sclk_q <= 1'b1;
      cnt_q  <= 6'h00;
      cmd_q  <= 8'h00;
      gap_cnt_q <= 16'hffff;
    end else begin
      sclk_q <= sclk;
      if (byte_end) begin
        gap_cnt_q <= 16'h0000;
      end else if (gap_cnt_q != 16'hffff) begin
        gap_cnt_q <= gap_cnt_q + 16'h0001;
      end
      if (chip_sel_n) begin
        cnt_q <= 6'h00;
      end else if (fall) begin
        cnt_q <= cnt_q + 6'h01;
        if (cnt_q < 6'h08) begin
          cmd_q <= {cmd_q[6:0], din};
        end
      end
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_past_end;
    lim_hit [*6];
  endsequence
  chk_oe_desel_off: assert property (chip_sel_n [*4] |-> !dout_oe)
    else $error("Data out still driven while deselected");
  chk_launch_on_rise: assert property (($changed(dout) && dout_oe && $past(dout_oe)) |-> sclk)
    else $error("Data out changed while serial clock low");
  chk_read_start: assert property ($rose(dout_oe) |-> sclk && cnt_q == 6'h08 && !cmd_q[7])
    else $error("Data out enabled outside a read data phase start");
  chk_oe_release: assert property ($fell(dout_oe) |-> !sclk || chip_sel_n)
    else $error("Data out released at wrong moment");
  chk_cmd_quiet: assert property ((!chip_sel_n && cnt_q < 6'h08) |-> !dout_oe)
    else $error("Data out driven during command byte");
  chk_write_quiet: assert property ((cmd_q[7] && cnt_q >= 6'h08) |-> !dout_oe)
    else $error("Data out driven during a write");
  chk_read_ends: assert property (s_past_end |-> !dout_oe)
    else $error("Data out driven past last register bit");
  chk_cs_full: assert property ($rose(chip_sel_n) |-> $past(cnt_q) == $past(lim))
    else $error("Chip select raised before last register bit");
  chk_byte_spacing: assert property (byte_end |-> gap_cnt_q >= 16'(`MSP_BYTE_GAP_CYC))
    else $error("Byte ended too soon after the previous byte");
endmodule
